// File: src/nvm_section_protection.sv
`timescale 1ns/100ps
// How it works
// - cpu flash stores work only from boot code
// - boot stores reach all flash, boot included
// - flash locations are 16-bit words
// - table region below boot, boot-sized, own lock
// - application and boot have separate lock bits
// - each lock field blocks reads, writes, both
// - factory row readable, never written or erased
// - calibration bytes loaded during reset
// - factory row holds type id and serial
// - user row one page, read/write by both
// - chip erase keeps user row intact
// - fuses written only by the programmer
// - lock writes accepted only when no bit loosens
// - chip erase clears locks after flash
// - unprogrammed bits read one, programmed zero
module nvm_section_protection
    import nvm_prot_pkg::*;
#(
    parameter int FLASH_AW = 8,
    parameter int BOOT_AW = 5,
    parameter int PAGE_AW = 4
) (
    input wire logic CLOCK_IN,
    input wire logic NRST_IN,
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    input wire logic [FLASH_AW-1:0] CPU_PC_IN,
    input wire logic PROG_REQ_IN,
    input wire logic [3:0] PROG_CMD_IN,
    input wire logic [15:0] PROG_ADDR_IN,
    input wire logic [15:0] PROG_WDATA_IN,
    output logic PROG_BUSY_OUT,
    output logic PROG_DONE_OUT,
    output logic PROG_REFUSED_OUT,
    output logic [15:0] PROG_RDATA_OUT,
    output logic [31:0] FUSES_OUT,
    output logic [7:0] LOCKS_OUT,
    output logic [7:0] CAL_OSC_OUT,
    output logic [7:0] CAL_ADC_OUT
);
    localparam logic [FLASH_AW-1:0] LAST_WORD = '1;
    // =======================================================
    // storage
    logic [15:0] flash_mem [2**FLASH_AW];
    logic [15:0] usig_mem [2**PAGE_AW]; // one page
    logic flash_we, usig_we, usig_clr, erase_we;
    logic [FLASH_AW-1:0] erase_idx, cnt_q, cnt_d;
    // software registers and control state
    logic [15:0] addr_q, addr_d, data_q, data_d, prdata_q, prdata_d;
    logic [3:0] cmd_q, cmd_d;
    logic [7:0] lock_q, lock_d, rdata_q, rdata_d, cal_osc_q, cal_adc_q;
    logic [31:0] fuse_q, fuse_d;
    nvm_state_t state_q, state_d;
    logic refused_q, refused_d, done_q, done_d, prefused_q, prefused_d;
    // the command being carried out this cycle
    logic busy, cpu_go, op_valid, op_prog, ok, pc_boot, sec_rd_ok, sec_wr_ok;
    logic [3:0] op_cmd;
    logic [15:0] op_addr, op_wdata, result;
    logic [7:0] psig_byte;
    // =======================================================
    // helpers: one guard for the operand address
    flash_section_guard #(.FLASH_AW(FLASH_AW), .BOOT_AW(BOOT_AW)) u_op_guard (
        .addr_in(op_addr[FLASH_AW-1:0]), .lock_in(lock_q),
        .in_boot_out(), .rd_ok_out(sec_rd_ok), .wr_ok_out(sec_wr_ok));
    // only the section of the fetch address matters here
    flash_section_guard #(.FLASH_AW(FLASH_AW), .BOOT_AW(BOOT_AW)) u_pc_guard (
        .addr_in(CPU_PC_IN), .lock_in(lock_q), .in_boot_out(pc_boot),
        .rd_ok_out(), .wr_ok_out());
    // factory row bytes, looked up by the low address bits
    sig_row_rom u_sig_row (.index_in(op_addr[4:0]), .byte_out(psig_byte));
    // =======================================================
    // request selection: programmer wins a tie
    always_comb begin
        busy = (state_q != ST_IDLE);
        cpu_go = REG_WR_IN && (REG_ADDR_IN == OFS_CTRLA)
            && REG_WDATA_IN[CTRLA_EXEC_BIT];
        op_valid = !busy && (PROG_REQ_IN || cpu_go);
        op_prog = PROG_REQ_IN;
        op_cmd = PROG_REQ_IN ? PROG_CMD_IN : cmd_q;
        op_addr = PROG_REQ_IN ? PROG_ADDR_IN : addr_q;
        op_wdata = PROG_REQ_IN ? PROG_WDATA_IN : data_q;
    end
    // =======================================================
    // command decode, access checks and next state
    always_comb begin
        ok = 1'b0;
        result = 16'h0000;
        flash_we = 1'b0;
        usig_we = 1'b0;
        usig_clr = 1'b0;
        lock_d = lock_q;
        fuse_d = fuse_q;
        state_d = state_q;
        cnt_d = cnt_q;
        erase_we = 1'b0;
        erase_idx = cnt_q;
        case (state_q)
            ST_IDLE: begin
                case (op_cmd)
                    CMD_FLASH_RD: begin
                        ok = sec_rd_ok;
                        result = flash_mem[op_addr[FLASH_AW-1:0]];
                    end
                    CMD_FLASH_WR: begin
                        // any write-unlocked address; the cpu only from boot
                        ok = sec_wr_ok && (op_prog || pc_boot);
                        flash_we = op_valid && ok;
                    end
                    CMD_USIG_RD: begin
                        ok = 1'b1;
                        result = usig_mem[op_addr[PAGE_AW-1:0]];
                    end
                    CMD_USIG_WR: begin
                        ok = 1'b1;
                        usig_we = op_valid;
                    end
                    CMD_USIG_ER: begin
                        ok = 1'b1; // its own erase
                        usig_clr = op_valid;
                    end
                    CMD_PSIG_RD: begin
                        ok = 1'b1;
                        result = {8'h00, psig_byte};
                    end
                    CMD_FUSE_RD: begin
                        ok = 1'b1;
                        result = {8'h00, fuse_q[op_addr[1:0]*8 +: 8]};
                    end
                    CMD_FUSE_WR: begin
                        ok = op_prog;
                        if (op_valid && ok) begin
                            fuse_d[op_addr[1:0]*8 +: 8] = op_wdata[7:0];
                        end
                    end
                    CMD_LOCK_RD: begin
                        ok = 1'b1;
                        result = {8'h00, lock_q};
                    end
                    CMD_LOCK_WR: begin
                        // no bit may go from zero back to one
                        ok = ((~lock_q & op_wdata[7:0]) == 8'h00);
                        if (op_valid && ok) begin
                            lock_d = lock_q & op_wdata[7:0];
                        end
                    end
                    CMD_CHIP_ER: begin
                        ok = op_prog;
                        if (op_valid && ok) begin
                            state_d = ST_ERASE;
                            cnt_d = '0;
                        end
                    end
                    // factory row write and unknown codes
                    default: ok = 1'b0;
                endcase
            end
            ST_ERASE: begin
                // flash only, user row is left alone
                erase_we = 1'b1;
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == LAST_WORD) begin
                    state_d = ST_LOCKCLR;
                end
            end
            ST_LOCKCLR: begin
                lock_d = LOCK_RST; // only after flash is clean
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end
    // =======================================================
    // software register writes and answers
    always_comb begin
        addr_d = addr_q;
        data_d = data_q;
        cmd_d = cmd_q;
        refused_d = refused_q;
        done_d = 1'b0;
        prefused_d = 1'b0;
        prdata_d = prdata_q;
        rdata_d = 8'h00;
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                OFS_ADDR0: addr_d[7:0] = REG_WDATA_IN;
                OFS_ADDR1: addr_d[15:8] = REG_WDATA_IN;
                OFS_DATA0: data_d[7:0] = REG_WDATA_IN;
                OFS_DATA1: data_d[15:8] = REG_WDATA_IN;
                OFS_CMD: cmd_d = REG_WDATA_IN[3:0];
                default: ; // exec bit handled above
            endcase
        end
        // a cpu start lost to busy or to the programmer
        if (cpu_go && (busy || PROG_REQ_IN)) begin
            refused_d = 1'b1;
        end else if (cpu_go) begin
            refused_d = !ok;
            if (ok) begin
                data_d = result;
            end
        end
        if (PROG_REQ_IN && busy) begin
            prefused_d = 1'b1;
        end else if (PROG_REQ_IN) begin
            prefused_d = !ok;
            done_d = (op_cmd != CMD_CHIP_ER) || !ok;
            if (ok) begin
                prdata_d = result;
            end
        end
        if (state_q == ST_LOCKCLR) begin
            done_d = 1'b1; // chip erase ends here
        end
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                OFS_ADDR0: rdata_d = addr_q[7:0];
                OFS_ADDR1: rdata_d = addr_q[15:8];
                OFS_DATA0: rdata_d = data_q[7:0];
                OFS_DATA1: rdata_d = data_q[15:8];
                OFS_CMD: rdata_d = {4'h0, cmd_q};
                OFS_STATUS: begin
                    rdata_d[ST_BUSY_BIT] = busy;
                    rdata_d[ST_REFUSED_BIT] = refused_q;
                    rdata_d[ST_BOOT_BIT] = pc_boot;
                end
                default: rdata_d = 8'h00; // unmapped reads zero
            endcase
        end
    end
    // =======================================================
    // registers
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            addr_q <= 16'h0000;
            data_q <= 16'h0000;
            cmd_q <= CMD_RST;
            refused_q <= 1'b0;
            lock_q <= LOCK_RST;
            fuse_q <= FUSE_RST;
            rdata_q <= 8'h00;
            state_q <= ST_IDLE;
            cnt_q <= '0;
            done_q <= 1'b0;
            prefused_q <= 1'b0;
            prdata_q <= 16'h0000;
            cal_osc_q <= CAL_OSC_VAL; // no software help
            cal_adc_q <= CAL_ADC_VAL;
        end else begin
            addr_q <= addr_d;
            data_q <= data_d;
            cmd_q <= cmd_d;
            refused_q <= refused_d;
            lock_q <= lock_d;
            fuse_q <= fuse_d;
            rdata_q <= rdata_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            prefused_q <= prefused_d;
            prdata_q <= prdata_d;
        end
    end
    // arrays carry no reset: contents are undefined until erased
    always_ff @(posedge CLOCK_IN) begin
        if (erase_we) begin
            flash_mem[erase_idx] <= ERASED_WORD;
        end else if (flash_we) begin
            flash_mem[op_addr[FLASH_AW-1:0]] <= op_wdata;
        end
        if (usig_clr) begin
            for (int i = 0; i < 2**PAGE_AW; i++) begin
                usig_mem[i] <= ERASED_WORD;
            end
        end else if (usig_we) begin
            usig_mem[op_addr[PAGE_AW-1:0]] <= op_wdata;
        end
    end
    assign REG_RDATA_OUT = rdata_q;
    assign PROG_BUSY_OUT = busy;
    assign PROG_DONE_OUT = done_q;
    assign PROG_REFUSED_OUT = prefused_q;
    assign PROG_RDATA_OUT = prdata_q;
    assign FUSES_OUT = fuse_q;
    assign LOCKS_OUT = lock_q;
    assign CAL_OSC_OUT = cal_osc_q;
    assign CAL_ADC_OUT = cal_adc_q;
    // =======================================================
    // checks
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!NRST_IN);
    AST_APP_STORE: assert property (
        cpu_go && !busy && !PROG_REQ_IN && op_cmd == CMD_FLASH_WR
        && !pc_boot |-> !flash_we ##1 refused_q)
        else $error("store from application section took effect");
    AST_BOOT_STORE: assert property (
        flash_we |=> flash_mem[$past(op_addr[FLASH_AW-1:0])]
        == $past(op_wdata))
        else $error("accepted flash store not written");
    AST_READ_LOCK: assert property (
        PROG_REQ_IN && !busy && op_cmd == CMD_FLASH_RD && !sec_rd_ok
        |=> PROG_REFUSED_OUT && PROG_DONE_OUT)
        else $error("read of read-locked section not refused");
    AST_PSIG_RO: assert property (
        PROG_REQ_IN && !busy && op_cmd == CMD_PSIG_WR |=> PROG_REFUSED_OUT)
        else $error("factory row write not refused");
    AST_CAL_LOAD: assert property (
        $rose(NRST_IN) |-> CAL_OSC_OUT == CAL_OSC_VAL
        && CAL_ADC_OUT == CAL_ADC_VAL)
        else $error("calibration not loaded at reset");
    AST_USIG_KEPT: assert property (
        state_q == ST_ERASE |-> !usig_we && !usig_clr)
        else $error("user row touched by chip erase");
    AST_FUSE_CPU: assert property (
        !PROG_REQ_IN |=> $stable(fuse_q))
        else $error("fuses changed without programmer");
    AST_LOCK_STRICT: assert property (
        state_q != ST_LOCKCLR |=> (lock_q & ~$past(lock_q)) == 8'h00)
        else $error("lock bit loosened outside chip erase");
    AST_LOCK_AND: assert property (
        op_valid && op_cmd == CMD_LOCK_WR && ok
        |=> lock_q == ($past(lock_q) & $past(op_wdata[7:0])))
        else $error("lock write not combined by and");
    AST_LOCK_LAST: assert property (
        state_q == ST_LOCKCLR |-> $past(state_q) == ST_ERASE
        && $past(cnt_q) == LAST_WORD ##1 lock_q == LOCK_RST)
        else $error("locks cleared before flash erase ended");
    COV_CHIP_ERASE: cover property (state_q == ST_LOCKCLR ##1 done_q);
    COV_BOOT_STORE: cover property (flash_we && !op_prog);
    COV_LOCK_TIGHT: cover property (op_valid && op_cmd == CMD_LOCK_WR && ok);
    COV_USIG_ERASE: cover property (usig_clr);
endmodule

// File: src/nvm_prot_pkg.sv
// ==========================================================
// shared constants of the flash protection block
package nvm_prot_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] OFS_ADDR0 = 4'h0;
    localparam logic [3:0] OFS_ADDR1 = 4'h1;
    localparam logic [3:0] OFS_DATA0 = 4'h2;
    localparam logic [3:0] OFS_DATA1 = 4'h3;
    localparam logic [3:0] OFS_CMD = 4'h4;
    localparam logic [3:0] OFS_CTRLA = 4'h5;
    localparam logic [3:0] OFS_STATUS = 4'h6;
    // field positions
    localparam int CTRLA_EXEC_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_BOOT_BIT = 2;
    localparam int LOCK_APP_LSB = 0;
    localparam int LOCK_TBL_LSB = 2;
    localparam int LOCK_BOOT_LSB = 4;
    localparam int LK_WR_BIT = 0;
    localparam int LK_RD_BIT = 1;
    // reset values: unprogrammed bits read as one
    localparam logic [7:0] LOCK_RST = 8'hff;
    localparam logic [31:0] FUSE_RST = 32'hffff_ffff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [3:0] CMD_RST = 4'h0;
    // factory calibration bytes and signature row layout
    localparam logic [7:0] CAL_OSC_VAL = 8'h80;
    localparam logic [7:0] CAL_ADC_VAL = 8'h40;
    localparam logic [4:0] SIG_ID0 = 5'h00;
    localparam logic [4:0] SIG_LOT0 = 5'h03;
    localparam logic [4:0] SIG_WAFER = 5'h09;
    localparam logic [4:0] SIG_X0 = 5'h0a;
    localparam logic [4:0] SIG_Y0 = 5'h0c;
    localparam logic [4:0] SIG_CAL_OSC = 5'h0e;
    localparam logic [4:0] SIG_CAL_ADC = 5'h0f;
    // commands
    localparam logic [3:0] CMD_FLASH_RD = 4'h1;
    localparam logic [3:0] CMD_FLASH_WR = 4'h2;
    localparam logic [3:0] CMD_USIG_RD = 4'h3;
    localparam logic [3:0] CMD_USIG_WR = 4'h4;
    localparam logic [3:0] CMD_USIG_ER = 4'h5;
    localparam logic [3:0] CMD_PSIG_RD = 4'h6;
    localparam logic [3:0] CMD_PSIG_WR = 4'h7;
    localparam logic [3:0] CMD_FUSE_RD = 4'h8;
    localparam logic [3:0] CMD_FUSE_WR = 4'h9;
    localparam logic [3:0] CMD_LOCK_RD = 4'ha;
    localparam logic [3:0] CMD_LOCK_WR = 4'hb;
    localparam logic [3:0] CMD_CHIP_ER = 4'hc;
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_LOCKCLR} nvm_state_t;
endpackage

// File: src/flash_section_guard.sv
`timescale 1ns/100ps
// ==========================================================
// maps a flash word address to its section and lock field
module flash_section_guard
    import nvm_prot_pkg::*;
#(
    parameter int FLASH_AW = 8,
    parameter int BOOT_AW = 5
) (
    input wire logic [FLASH_AW-1:0] addr_in,
    input wire logic [7:0] lock_in,
    output logic in_boot_out,
    output logic rd_ok_out,
    output logic wr_ok_out
);
    // boot sits at the top, the table just below it, same size
    localparam logic [FLASH_AW-1:0] BOOT_START =
        FLASH_AW'(2**FLASH_AW - 2**BOOT_AW);
    localparam logic [FLASH_AW-1:0] TBL_START =
        FLASH_AW'(2**FLASH_AW - 2 * 2**BOOT_AW);
    logic [1:0] field; // lock field of the addressed section

    // =======================================================
    // section decode
    always_comb begin
        in_boot_out = (addr_in >= BOOT_START);
        if (in_boot_out) begin // boot has its own field
            field = lock_in[LOCK_BOOT_LSB +: 2];
        end else if (addr_in >= TBL_START) begin
            field = lock_in[LOCK_TBL_LSB +: 2];
        end else begin
            field = lock_in[LOCK_APP_LSB +: 2];
        end
        rd_ok_out = field[LK_RD_BIT];
        wr_ok_out = field[LK_WR_BIT];
    end
endmodule

// File: src/sig_row_rom.sv
`timescale 1ns/100ps
// ==========================================================
// factory signature row: constants only, no write path
module sig_row_rom
    import nvm_prot_pkg::*;
#(
    // identity and serial values below are arbitrary
    parameter logic [23:0] DEVICE_ID = 24'h123456,
    parameter logic [47:0] LOT_NUM = 48'h0102_0304_0506,
    parameter logic [7:0] WAFER_NUM = 8'h07,
    parameter logic [15:0] DIE_X = 16'h0008,
    parameter logic [15:0] DIE_Y = 16'h0009
) (
    input wire logic [4:0] index_in,
    output logic [7:0] byte_out
);
    logic [4:0] rel; // offset inside a multi-byte field

    // =======================================================
    // byte lookup
    always_comb begin
        rel = 5'h00;
        byte_out = 8'hff; // unused bytes read as erased
        if (index_in < SIG_LOT0) begin
            rel = index_in - SIG_ID0;
            byte_out = DEVICE_ID[rel[1:0]*8 +: 8];
        end else if (index_in < SIG_WAFER) begin
            rel = index_in - SIG_LOT0;
            byte_out = LOT_NUM[rel[2:0]*8 +: 8];
        end else if (index_in == SIG_WAFER) begin
            byte_out = WAFER_NUM;
        end else if (index_in < SIG_Y0) begin
            rel = index_in - SIG_X0;
            byte_out = DIE_X[rel[0]*8 +: 8];
        end else if (index_in < SIG_CAL_OSC) begin
            rel = index_in - SIG_Y0;
            byte_out = DIE_Y[rel[0]*8 +: 8];
        end else if (index_in == SIG_CAL_OSC) begin
            byte_out = CAL_OSC_VAL;
        end else if (index_in == SIG_CAL_ADC) begin
            byte_out = CAL_ADC_VAL;
        end
    end
endmodule

// File: verif/prog_model.sv
`timescale 1ns/100ps
// ==========================================================
// external programmer: one request pulse, then waits for answer
module prog_model (
    input wire logic clk_in,
    input wire logic done_in,
    input wire logic refused_in,
    output logic req_out,
    output logic [3:0] cmd_out,
    output logic [15:0] addr_out,
    output logic [15:0] wdata_out
);
    // idle bus before the first request
    initial begin
        req_out = 1'b0;
        cmd_out = 4'h0;
        addr_out = 16'h0000;
        wdata_out = 16'h0000;
    end
    // released lines show the inverse, so stale values never match
    task automatic issue(input logic [3:0] c, input logic [15:0] a,
            input logic [15:0] d, output logic ok);
        int n;
        n = 0;
        @(posedge clk_in);
        req_out <= 1'b1;
        cmd_out <= c;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        req_out <= 1'b0;
        cmd_out <= ~c;
        addr_out <= ~a;
        wdata_out <= ~d;
        // bounded wait: erase sweep is the longest answer
        do begin
            @(negedge clk_in);
            n++;
        end while (!(done_in || refused_in) && n < 400);
        ok = (n < 400);
    endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench: drivers queue notes, monitor compares
module testbench;
    import nvm_prot_pkg::*;
    localparam int FAW = 7; // short erase sweep, boot at 60..7f
    typedef struct {logic rf; logic ck; logic [15:0] rd;} note_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] ra = 4'h0;
    logic [7:0] wd = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [FAW-1:0] pc = '0;
    logic [7:0] rdat, cal_o, cal_a, locks;
    logic req, busy, dn, rf, rd_seen;
    logic [3:0] cmd;
    logic [15:0] pa, pw, prd;
    logic [31:0] fuses;
    logic [31:0] seed = 32'h0000005f;
    note_t pq[$];
    logic [7:0] rq[$];
    int n_fail = 0;
    int comparisons = 0;

    always #12.5 clk = ~clk;

    nvm_section_protection #(.FLASH_AW(FAW), .BOOT_AW(5), .PAGE_AW(4)) dut (
        .CLOCK_IN(clk), .NRST_IN(nrst), .REG_ADDR_IN(ra),
        .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_RDATA_OUT(rdat), .CPU_PC_IN(pc), .PROG_REQ_IN(req),
        .PROG_CMD_IN(cmd), .PROG_ADDR_IN(pa), .PROG_WDATA_IN(pw),
        .PROG_BUSY_OUT(busy), .PROG_DONE_OUT(dn), .PROG_REFUSED_OUT(rf),
        .PROG_RDATA_OUT(prd), .FUSES_OUT(fuses), .LOCKS_OUT(locks),
        .CAL_OSC_OUT(cal_o), .CAL_ADC_OUT(cal_a));
    prog_model pm (.clk_in(clk), .done_in(dn), .refused_in(rf),
        .req_out(req), .cmd_out(cmd), .addr_out(pa), .wdata_out(pw));

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic check(input string nm, input logic [31:0] s,
            input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // ======================================================
    // monitor: read data stands only the cycle after the strobe
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        note_t n;
        if (rd_seen === 1'b1) begin
            if (rq.size() == 0) n_fail++;
            else check("reg rdata", {24'h0, rdat},
                {24'h0, rq.pop_front()});
        end
        if (dn === 1'b1 || rf === 1'b1) begin
            if (pq.size() == 0) n_fail++;
            else begin
                n = pq.pop_front();
                check("prog refused", {31'h0, rf},
                    {31'h0, n.rf});
                if (n.ck) check("prog rdata", {16'h0, prd},
                    {16'h0, n.rd});
            end
        end
    end
    // ======================================================
    // register port and command tasks
    task automatic rw(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rr(input logic [3:0] a, input logic [7:0] e);
        rq.push_back(e);
        @(posedge clk);
        rd <= 1'b1;
        ra <= a;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // status: bit2 pc in boot, bit1 refused, bit0 busy
    task automatic cpu(input logic [3:0] c, input logic [15:0] a,
            input logic [15:0] d, input logic [FAW-1:0] p, input logic r);
        pc <= p;
        rw(OFS_ADDR0, a[7:0]);
        rw(OFS_ADDR1, a[15:8]);
        rw(OFS_DATA0, d[7:0]);
        rw(OFS_DATA1, d[15:8]);
        rw(OFS_CMD, {4'h0, c});
        rw(OFS_CTRLA, 8'h01);
        rr(OFS_STATUS, {5'h00, p[FAW-1:FAW-2] == 2'b11, r, 1'b0});
    endtask
    task automatic pcmd(input logic [3:0] c, input logic [15:0] a,
            input logic [15:0] d, input logic r, input logic k,
            input logic [15:0] e);
        logic ok;
        pq.push_back('{r, k, e});
        pm.issue(c, a, d, ok);
        if (!ok) n_fail++;
    endtask
    task automatic print_verdict();
        $display("counts: %0d comparisons, %0d mismatches", comparisons,
            n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog: whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    // ======================================================
    // main sequence
    initial begin
        logic [15:0] w, v, u;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check("fuses", fuses, FUSE_RST);
        check("locks", {24'h0, locks}, {24'h0, LOCK_RST});
        check("cal", {cal_o, cal_a}, {CAL_OSC_VAL, CAL_ADC_VAL});
        $display("test reset done");
        u = rnd();
        v = rnd();
        pcmd(CMD_USIG_ER, 16'h0000, 16'h0, 1'b0, 1'b0, 16'h0);
        pcmd(CMD_USIG_RD, 16'h0002, 16'h0, 1'b0, 1'b1,
            ERASED_WORD);
        pcmd(CMD_USIG_WR, 16'h0003, u, 1'b0, 1'b0, 16'h0);
        cpu(CMD_USIG_WR, 16'h000f, v, 7'h00, 1'b0);
        pcmd(CMD_USIG_RD, 16'h000f, 16'h0, 1'b0, 1'b1, v);
        cpu(CMD_USIG_RD, 16'h0003, 16'h0, 7'h00, 1'b0);
        rr(OFS_DATA1, u[15:8]);
        pcmd(CMD_CHIP_ER, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0);
        $display("test user row done");
        pcmd(CMD_PSIG_WR, 16'h000e, 16'h0, 1'b1, 1'b0, 16'h0);
        cpu(CMD_PSIG_WR, 16'h000e, 16'h0, 7'h70, 1'b1);
        pcmd(CMD_PSIG_RD, {11'h0, SIG_CAL_OSC}, 16'h0, 1'b0, 1'b1,
            {8'h00, CAL_OSC_VAL});
        cpu(CMD_PSIG_RD, {11'h0, SIG_CAL_ADC}, 16'h0, 7'h00,
            1'b0);
        rr(OFS_DATA0, CAL_ADC_VAL);
        v = rnd();
        pcmd(CMD_FUSE_WR, 16'h0001, {8'h00, v[7:0]}, 1'b0, 1'b0,
            16'h0);
        cpu(CMD_FUSE_WR, 16'h0001, 16'h00ff, 7'h70, 1'b1);
        cpu(CMD_FUSE_RD, 16'h0001, 16'h0, 7'h00, 1'b0);
        rr(OFS_DATA0, v[7:0]);
        rr(OFS_CMD, {4'h0, CMD_FUSE_RD});
        rr(OFS_ADDR0, 8'h01);
        rr(OFS_ADDR1, 8'h00);
        rr(4'hf, 8'h00);
        @(negedge clk);
        check("fuses", fuses, {16'hffff, v[7:0], 8'hff});
        $display("test factory row and fuses done");
        pcmd(CMD_LOCK_WR, 16'h0, 16'h00fe, 1'b0, 1'b0, 16'h0);
        cpu(CMD_LOCK_WR, 16'h0, 16'h00ff, 7'h00, 1'b1);
        cpu(CMD_LOCK_WR, 16'h0, 16'h00f6, 7'h00, 1'b0);
        pcmd(CMD_LOCK_RD, 16'h0, 16'h0, 1'b0, 1'b1, 16'h00f6);
        w = rnd();
        v = rnd();
        pcmd(CMD_FLASH_WR, 16'h000a, w, 1'b1, 1'b0, 16'h0);
        pcmd(CMD_FLASH_RD, 16'h000a, 16'h0, 1'b0, 1'b1,
            ERASED_WORD);
        pcmd(CMD_FLASH_WR, 16'h0046, w, 1'b0, 1'b0, 16'h0);
        pcmd(CMD_FLASH_RD, 16'h0046, 16'h0, 1'b1, 1'b0, 16'h0);
        pcmd(CMD_FLASH_WR, 16'h0064, v, 1'b0, 1'b0, 16'h0);
        pcmd(CMD_FLASH_RD, 16'h0064, 16'h0, 1'b0, 1'b1, v);
        cpu(CMD_FLASH_RD, 16'h0046, 16'h0, 7'h60, 1'b1);
        $display("test locks done");
        cpu(CMD_FLASH_WR, 16'h0065, w, 7'h3f, 1'b1);
        cpu(CMD_FLASH_WR, 16'h0065, w, 7'h5f, 1'b1);
        cpu(CMD_FLASH_WR, 16'h0065, w, 7'h60, 1'b0);
        pcmd(CMD_FLASH_RD, 16'h0065, 16'h0, 1'b0, 1'b1, w);
        $display("test flash store done");
        fork
            pcmd(CMD_CHIP_ER, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0);
            begin
                repeat (100) @(negedge clk);
                check("busy", {31'h0, busy}, 32'h1);
                check("locks", {24'h0, locks}, 32'hf6);
            end
        join
        @(negedge clk);
        check("locks", {24'h0, locks}, 32'hff);
        pcmd(CMD_FLASH_RD, 16'h0065, 16'h0, 1'b0, 1'b1,
            ERASED_WORD);
        pcmd(CMD_USIG_RD, 16'h0003, 16'h0, 1'b0, 1'b1, u);
        repeat (2) @(negedge clk);
        $display("test chip erase done");
        n_fail += pq.size() + rq.size();
        print_verdict();
    end
endmodule
